// [core/nfc_timer_pkg.sv]
// Purpose: constants shared by the protocol timer unit
// Assumes: 32-bit register words, byte addresses below
// Notes:   offsets are byte addresses of aligned words
package nfc_timer_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] NRT_OFS = 8'h04;
   localparam logic [7:0] GPT_OFS = 8'h08;
   localparam logic [7:0] PFW_OFS = 8'h0C;
   localparam logic [7:0] WUT_OFS = 8'h10;
   localparam logic [7:0] CMD_OFS = 8'h14;
   localparam logic [7:0] IRQ_OFS = 8'h18;
   localparam logic [7:0] STAT_OFS = 8'h1C;

   // ---------------------------------------------------------------
   // control register fields and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_NRT_STEP = 0;
   localparam int unsigned CTRL_NRT_UNCOND = 1;
   localparam int unsigned CTRL_NRT_PEER = 2;
   localparam int unsigned CTRL_GPT_TRIG = 3;
   localparam int unsigned CTRL_MODE = 5;
   localparam int unsigned CTRL_FD_EN = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_RESET = 32'h0000_0010;

   // ---------------------------------------------------------------
   // command and interrupt flag bits
   // ---------------------------------------------------------------
   localparam int unsigned CMD_NRT_START = 0;
   localparam int unsigned CMD_NRT_STOP = 1;
   localparam int unsigned CMD_GPT_START = 2;
   localparam int unsigned CMD_WUT_START = 3;
   localparam int unsigned CMD_STOP_ALL = 4;
   localparam int unsigned CMD_W = 5;
   localparam int unsigned IRQ_NRT = 0;
   localparam int unsigned IRQ_GPT = 1;
   localparam int unsigned IRQ_PFW = 2;
   localparam int unsigned IRQ_FD_ON = 3;
   localparam int unsigned IRQ_FD_OFF = 4;
   localparam int unsigned IRQ_WUT = 5;
   localparam int unsigned IRQ_W = 6;

   // ---------------------------------------------------------------
   // timer steps in carrier periods, minus one
   // ---------------------------------------------------------------
   localparam logic [11:0] STEP_FINE_M1 = 12'h03F;
   localparam logic [11:0] STEP_COARSE_M1 = 12'hFFF;
   localparam logic [11:0] STEP_OTHER_M1 = 12'h03F;

   // ---------------------------------------------------------------
   // modes, trigger sources, bus answers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_READER = 3'b000,
      MODE_ACT_INIT = 3'b001,
      MODE_ACT_TGT = 3'b010,
      MODE_BITRATE = 3'b011,
      MODE_PAS_TGT = 3'b100,
      MODE_WAKEUP = 3'b101,
      MODE_POWER_DOWN = 3'b110,
      MODE_SPARE = 3'b111
   } op_mode_e;
   localparam logic [1:0] GPT_TRIG_NONE = 2'h0;
   localparam logic [1:0] GPT_TRIG_SOF = 2'h1;
   localparam logic [1:0] GPT_TRIG_EOF = 2'h2;
   localparam logic [1:0] GPT_TRIG_FIELD_OFF = 2'h3;
   localparam logic [1:0] FD_PEER = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : nfc_timer_pkg

// [core/nfc_protocol_timers.sv]
// Purpose: protocol timers of an NFC front end, AXI4-Lite registers
// Assumes: fc_tick_i pulses once per carrier period, rc_tick_i once
//          per wake-up step; all inputs synchronous to clk_i
// Notes:   no-response, peer-field wait, general and wake-up timers
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module nfc_protocol_timers #(
   parameter int unsigned CNT_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // axi4-lite write address and data
   input wire logic s_axi_awvalid_i,
   input wire logic [7:0] s_axi_awaddr_i,
   output logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic s_axi_bvalid_o,
   output logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic s_axi_arvalid_i,
   input wire logic [7:0] s_axi_araddr_i,
   output logic s_axi_arready_o,
   output logic s_axi_rvalid_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rready_i,
   // clock ticks
   input wire logic fc_tick_i,
   input wire logic rc_tick_i,
   // transmit, receive and field events
   input wire logic tx_done_i,
   input wire logic tx_field_off_i,
   input wire logic rx_start_i,
   input wire logic rx_end_i,
   input wire logic rx_busy_i,
   input wire logic ext_field_i,
   // controls to the front end
   output logic rx_on_o,
   output logic rc_osc_en_o,
   output logic [1:0] field_detector_enable_o
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie between 2 and 32");
   end

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   localparam int unsigned CMD_W_L = nfc_timer_pkg::CMD_W;
   logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_data, w_data_q;
   logic [7:0] aw_addr_q;
   logic [3:0] w_strb_q;
   logic aw_hs, w_hs, ar_hs, wr_do, wr_ok, rd_ok;
   logic [31:0] ctrl_q;
   logic [CNT_W-1:0] nrt_cfg_q, gpt_cfg_q, pfw_cfg_q, wut_cfg_q;
   logic [CMD_W_L-1:0] cmd_q;
   logic [nfc_timer_pkg::IRQ_W-1:0] irq_q, irq_set, irq_clr;
   logic ext_q, field_rise, field_fall, peer_det;
   logic rx_on_q, wut_run_q, wut_start, wut_expire;
   logic [CNT_W-1:0] wut_cnt_q;
   logic uncond, nfc_active, nfc_any, xtal_tick, stop_all;
   logic nrt_auto, gpt_trig_hit;
   logic [1:0] gpt_trig;
   nfc_timer_pkg::op_mode_e mode;
   logic [2:0] t_start, t_stop, t_run_q, t_expire;
   logic [CNT_W-1:0] t_cnt_q [3];
   logic [CNT_W-1:0] t_cfg [3];
   logic [11:0] t_pre_q [3];
   logic [11:0] t_step [3];

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   assign aw_hs = s_axi_awvalid_i & awready_q;
   assign w_hs = s_axi_wvalid_i & wready_q;
   assign wr_do = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_ok = aw_addr_q <= nfc_timer_pkg::STAT_OFS
      && aw_addr_q[1:0] == 2'h0;

   // address and data are taken in either order, one write at a time
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         aw_full_q <= 1'b0;
         awready_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else begin
         if (wr_do) begin
            aw_full_q <= 1'b0;
         end else if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (aw_hs) begin
            awready_q <= 1'b0;
         end else if (!aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
         end
      end
   end

   // write data holding
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         w_full_q <= 1'b0;
         wready_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (wr_do) begin
            w_full_q <= 1'b0;
         end else if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (w_hs) begin
            wready_q <= 1'b0;
         end else if (!w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= nfc_timer_pkg::RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? nfc_timer_pkg::RESP_OKAY
            : nfc_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   assign ar_hs = s_axi_arvalid_i & arready_q;

   // read decode
   always_comb begin
      rd_ok = s_axi_araddr_i[1:0] == 2'h0;
      unique case (s_axi_araddr_i)
         nfc_timer_pkg::CTRL_OFS: rd_data = ctrl_q;
         nfc_timer_pkg::NRT_OFS: rd_data = 32'(nrt_cfg_q);
         nfc_timer_pkg::GPT_OFS: rd_data = 32'(gpt_cfg_q);
         nfc_timer_pkg::PFW_OFS: rd_data = 32'(pfw_cfg_q);
         nfc_timer_pkg::WUT_OFS: rd_data = 32'(wut_cfg_q);
         nfc_timer_pkg::CMD_OFS: rd_data = 32'h0000_0000;
         nfc_timer_pkg::IRQ_OFS: rd_data = 32'(irq_q);
         nfc_timer_pkg::STAT_OFS: rd_data = 32'({ext_q, rx_on_q,
            wut_run_q, t_run_q});
         default: begin
            rd_data = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= nfc_timer_pkg::RESP_OKAY;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
         end else if (!rvalid_q) begin
            arready_q <= 1'b1;
         end
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_ok ? nfc_timer_pkg::RESP_OKAY
               : nfc_timer_pkg::RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration registers and commands
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_q <= nfc_timer_pkg::CTRL_RESET;
         nrt_cfg_q <= nfc_timer_pkg::CNT_RESET[CNT_W-1:0];
         gpt_cfg_q <= nfc_timer_pkg::CNT_RESET[CNT_W-1:0];
         pfw_cfg_q <= nfc_timer_pkg::CNT_RESET[CNT_W-1:0];
         wut_cfg_q <= nfc_timer_pkg::CNT_RESET[CNT_W-1:0];
      end else if (wr_do) begin
         unique case (aw_addr_q)
            nfc_timer_pkg::CTRL_OFS:
               ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
            nfc_timer_pkg::NRT_OFS: nrt_cfg_q <= CNT_W'(merge(
               32'(nrt_cfg_q), w_data_q, w_strb_q));
            nfc_timer_pkg::GPT_OFS: gpt_cfg_q <= CNT_W'(merge(
               32'(gpt_cfg_q), w_data_q, w_strb_q));
            nfc_timer_pkg::PFW_OFS: pfw_cfg_q <= CNT_W'(merge(
               32'(pfw_cfg_q), w_data_q, w_strb_q));
            nfc_timer_pkg::WUT_OFS: wut_cfg_q <= CNT_W'(merge(
               32'(wut_cfg_q), w_data_q, w_strb_q));
            default: ;
         endcase
      end
   end

   // command writes become one-cycle pulses
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_q <= '0;
      end else if (wr_do && aw_addr_q == nfc_timer_pkg::CMD_OFS
            && w_strb_q[0]) begin
         cmd_q <= w_data_q[CMD_W_L-1:0];
      end else begin
         cmd_q <= '0;
      end
   end

   // ---------------------------------------------------------------
   // mode decode and field edges
   // ---------------------------------------------------------------
   assign mode = nfc_timer_pkg::op_mode_e'(
      ctrl_q[nfc_timer_pkg::CTRL_MODE +: 3]);
   assign uncond = ctrl_q[nfc_timer_pkg::CTRL_NRT_UNCOND];
   assign gpt_trig = ctrl_q[nfc_timer_pkg::CTRL_GPT_TRIG +: 2];
   assign field_detector_enable_o = ctrl_q[nfc_timer_pkg::CTRL_FD_EN +: 2];
   assign peer_det = field_detector_enable_o == nfc_timer_pkg::FD_PEER;
   assign nfc_active = mode == nfc_timer_pkg::MODE_ACT_INIT
      || mode == nfc_timer_pkg::MODE_ACT_TGT;
   assign nfc_any = nfc_active || mode == nfc_timer_pkg::MODE_BITRATE
      || mode == nfc_timer_pkg::MODE_PAS_TGT;
   assign xtal_tick = fc_tick_i
      && mode != nfc_timer_pkg::MODE_POWER_DOWN;
   assign stop_all = cmd_q[nfc_timer_pkg::CMD_STOP_ALL];
   assign field_rise = ext_field_i & ~ext_q;
   assign field_fall = ~ext_field_i & ext_q;

   // previous field level for edge detection
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_field_i;
      end
   end

   // ---------------------------------------------------------------
   // start and stop sources of the crystal timers
   // ---------------------------------------------------------------
   // timer 0: no-response, 1: general purpose, 2: peer-field wait
   assign nrt_auto =
      (mode == nfc_timer_pkg::MODE_READER && tx_done_i)
      || ((nfc_active || mode == nfc_timer_pkg::MODE_BITRATE)
         && !ctrl_q[nfc_timer_pkg::CTRL_NRT_PEER]
         && tx_field_off_i)
      || (nfc_active && ctrl_q[nfc_timer_pkg::CTRL_NRT_PEER]
         && field_rise);
   assign t_start[0] = cmd_q[nfc_timer_pkg::CMD_NRT_START]
      || nrt_auto;
   assign t_stop[0] = cmd_q[nfc_timer_pkg::CMD_NRT_STOP]
      || (stop_all && !uncond)
      || (rx_start_i && !uncond);
   assign gpt_trig_hit =
      (gpt_trig == nfc_timer_pkg::GPT_TRIG_SOF && rx_start_i)
      || (gpt_trig == nfc_timer_pkg::GPT_TRIG_EOF && rx_end_i)
      || (gpt_trig == nfc_timer_pkg::GPT_TRIG_FIELD_OFF
         && nfc_active && tx_field_off_i);
   assign t_start[1] = cmd_q[nfc_timer_pkg::CMD_GPT_START]
      || gpt_trig_hit;
   assign t_stop[1] = stop_all;
   assign t_start[2] = nfc_any && tx_field_off_i;
   assign t_stop[2] = stop_all || field_rise;
   assign t_cfg[0] = nrt_cfg_q;
   assign t_cfg[1] = gpt_cfg_q;
   assign t_cfg[2] = pfw_cfg_q;
   assign t_step[0] = ctrl_q[nfc_timer_pkg::CTRL_NRT_STEP]
      ? nfc_timer_pkg::STEP_COARSE_M1
      : nfc_timer_pkg::STEP_FINE_M1;
   assign t_step[1] = nfc_timer_pkg::STEP_OTHER_M1;
   assign t_step[2] = nfc_timer_pkg::STEP_OTHER_M1;

   // ---------------------------------------------------------------
   // crystal-clocked down counters
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_timer
      // expiry when the last step of the count ends
      assign t_expire[g] = t_run_q[g] && xtal_tick && !t_start[g]
         && !t_stop[g] && t_pre_q[g] == t_step[g]
         && t_cnt_q[g] <= CNT_W'(1);

      // load on start, restart while running, stop silently
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            t_run_q[g] <= 1'b0;
            t_cnt_q[g] <= '0;
            t_pre_q[g] <= 12'h000;
         end else if (t_start[g]) begin
            t_run_q[g] <= 1'b1;
            t_cnt_q[g] <= t_cfg[g];
            t_pre_q[g] <= 12'h000;
         end else if (t_stop[g]) begin
            t_run_q[g] <= 1'b0;
         end else if (t_run_q[g] && xtal_tick) begin
            if (t_pre_q[g] == t_step[g]) begin
               t_pre_q[g] <= 12'h000;
               t_cnt_q[g] <= t_cnt_q[g] - CNT_W'(1);
               if (t_cnt_q[g] <= CNT_W'(1)) begin
                  t_run_q[g] <= 1'b0;
               end
            end else begin
               t_pre_q[g] <= t_pre_q[g] + 12'h001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // wake-up timer on the rc ticks
   // ---------------------------------------------------------------
   assign wut_start = (cmd_q[nfc_timer_pkg::CMD_WUT_START]
      && mode != nfc_timer_pkg::MODE_WAKEUP)
      || (mode == nfc_timer_pkg::MODE_PAS_TGT && field_rise);
   assign wut_expire = wut_run_q && rc_tick_i && !wut_start
      && !stop_all && wut_cnt_q <= CNT_W'(1);

   // rc tick keeps counting in power-down
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wut_run_q <= 1'b0;
         wut_cnt_q <= '0;
      end else if (wut_start) begin
         wut_run_q <= 1'b1;
         wut_cnt_q <= wut_cfg_q;
      end else if (stop_all) begin
         wut_run_q <= 1'b0;
      end else if (wut_run_q && rc_tick_i) begin
         wut_cnt_q <= wut_cnt_q - CNT_W'(1);
         if (wut_cnt_q <= CNT_W'(1)) begin
            wut_run_q <= 1'b0;
         end
      end
   end
   assign rc_osc_en_o = wut_run_q;

   // ---------------------------------------------------------------
   // receiver enable
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rx_on_q <= 1'b0;
      end else if (t_expire[0] && (!uncond || !rx_busy_i)) begin
         rx_on_q <= 1'b0;
      end else if (tx_done_i) begin
         rx_on_q <= 1'b1;
      end
   end
   assign rx_on_o = rx_on_q;

   // ---------------------------------------------------------------
   // sticky flags, write one to clear, set wins
   // ---------------------------------------------------------------
   assign irq_set = {wut_expire,
      field_fall && peer_det, field_rise && peer_det,
      t_expire[2], t_expire[1], t_expire[0]};
   assign irq_clr = (wr_do && aw_addr_q == nfc_timer_pkg::IRQ_OFS
      && w_strb_q[0]) ? w_data_q[nfc_timer_pkg::IRQ_W-1:0] : '0;

   // flag register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_q <= '0;
      end else begin
         irq_q <= (irq_q & ~irq_clr) | irq_set;
      end
   end

   // ---------------------------------------------------------------
   // bus outputs
   // ---------------------------------------------------------------
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

endmodule : nfc_protocol_timers

// [verification/nfc_timers_props.sv]
// Purpose: port checks of the timer unit
// Assumes: one clock, synchronous reset
// Notes: bound to the top module
`timescale 1ns/100ps
module nfc_timers_props (
   // clock, reset and bus handshakes
   input wire logic clk_i, reset_i,
   input wire logic s_axi_awvalid_i, s_axi_awready_o,
   input wire logic s_axi_wvalid_i, s_axi_wready_o,
   input wire logic s_axi_bvalid_o, s_axi_bready_i,
   input wire logic s_axi_arvalid_i, s_axi_arready_o,
   input wire logic s_axi_rvalid_o, s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   // receiver control
   input wire logic tx_done_i, rx_on_o
);
   // ---------------------------------------------
   // bus and receiver properties
   // ---------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
      else $error("late write answer");
   a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o) else $error("write answer dropped");
   a_write_closed: assert property (s_axi_bvalid_o
      |-> !s_axi_awready_o && !s_axi_wready_o) else $error("early write");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o) else $error("late read answer");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read lost");
   a_read_closed: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("early read");
   a_rx_on_set: assert property (tx_done_i |=> rx_on_o)
      else $error("receiver not enabled");
   a_rx_on_cause: assert property ($rose(rx_on_o) |-> $past(tx_done_i))
      else $error("receiver enabled alone");
endmodule : nfc_timers_props

bind nfc_protocol_timers nfc_timers_props u_props (
   .clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
   .tx_done_i(tx_done_i), .rx_on_o(rx_on_o)
);

// [verification/nfc_host_model.sv]
// Purpose: host side bus master
// Assumes: one write and one read at a time
// Notes: tasks are called by the bench
`timescale 1ns/100ps
module nfc_host_model (
   // clock and write channels
   input wire logic clk_i, awready_i, wready_i, bvalid_i,
   input wire logic [1:0] bresp_i,
   output logic awvalid_o, wvalid_o, bready_o,
   output logic [7:0] awaddr_o, araddr_o,
   output logic [31:0] wdata_o,
   output logic [3:0] wstrb_o,
   // read channels
   input wire logic arready_i, rvalid_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   output logic arvalid_o, rready_o
);
   // idle bus, full words only
   logic [1:0] last_bresp;
   assign wstrb_o = 4'hF;
   initial begin
      {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
      {awaddr_o, araddr_o, wdata_o} = 48'h0;
   end
   // write: one full word, wait for the answer and keep its response
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      awaddr_o <= a;
      wdata_o <= v;
      {awvalid_o, wvalid_o, bready_o} <= 3'h7;
      do begin
         @(posedge clk_i);
         if (awready_i) awvalid_o <= 1'h0;
         if (wready_i) wvalid_o <= 1'h0;
      end while (!bvalid_i);
      last_bresp = bresp_i;
      bready_o <= 1'h0;
   endtask : wr
   // read one word and its response
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      @(posedge clk_i);
      araddr_o <= a;
      {arvalid_o, rready_o} <= 2'h3;
      do begin
         @(posedge clk_i);
         if (arready_i) arvalid_o <= 1'h0;
      end while (!rvalid_i);
      v = rdata_i;
      r = rresp_i;
      rready_o <= 1'h0;
   endtask : rd
endmodule : nfc_host_model

// [verification/tb.sv]
// Purpose: self-checking bench of the timer unit
// Assumes: carrier tick every clock, small counts
// Notes: registers reached through the host model
`timescale 1ns/100ps
module tb;
   // stimulus and bus wires
   logic clk_i = 1'h0, reset_i = 1'h1, fc = 1'h1, fo = 1'h0, eor = 1'h0;
   logic tx_done = 1'h0, rx_st = 1'h0, busy = 1'h0, ext = 1'h0, rc = 1'h0;
   logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, rx_on, osc;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, d;
   logic [3:0] ws;
   logic [1:0] rrsp, brsp, fd, r;
   int num_errors = 0;
   int samples_checked = 0;
   always #4 clk_i = ~clk_i;
   nfc_protocol_timers #(.CNT_W(16)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(awv),
      .s_axi_awaddr_i(awa), .s_axi_awready_o(awr), .s_axi_wvalid_i(wv),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wready_o(wr),
      .s_axi_bvalid_o(bv), .s_axi_bresp_o(brsp), .s_axi_bready_i(br),
      .s_axi_arvalid_i(arv), .s_axi_araddr_i(ara), .s_axi_arready_o(arr),
      .s_axi_rvalid_o(rv), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrsp),
      .s_axi_rready_i(rr), .fc_tick_i(fc), .rc_tick_i(rc),
      .tx_done_i(tx_done), .tx_field_off_i(fo), .rx_start_i(rx_st),
      .rx_end_i(eor), .rx_busy_i(busy), .ext_field_i(ext), .rx_on_o(rx_on),
      .rc_osc_en_o(osc), .field_detector_enable_o(fd));
   nfc_host_model h (
      .clk_i(clk_i), .awready_i(awr), .wready_i(wr), .bvalid_i(bv),
      .bresp_i(brsp),
      .awvalid_o(awv), .wvalid_o(wv), .bready_o(br), .awaddr_o(awa),
      .araddr_o(ara), .wdata_o(wd), .wstrb_o(ws), .arready_i(arr),
      .rvalid_i(rv), .rdata_i(rdat), .rresp_i(rrsp), .arvalid_o(arv),
      .rready_o(rr));
   // compare and helpers
   task automatic chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      h.rd(a, d, r);
      chk($sformatf("word %h", a), d, e);
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic tx_end;
      @(posedge clk_i) tx_done <= 1'h1;
      @(posedge clk_i) tx_done <= 1'h0;
   endtask : tx_end
   task automatic results;
      if (num_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // watchdog
   initial begin
      cyc(20000);
      num_errors++;
      results();
   end
   // main sequence
   initial begin
      cyc(5);
      reset_i <= 1'h0;
      cyc(3);
      rdc(nfc_timer_pkg::CTRL_OFS, nfc_timer_pkg::CTRL_RESET);
      rdc(nfc_timer_pkg::NRT_OFS, nfc_timer_pkg::CNT_RESET);
      h.rd(8'h20, d, r);
      chk("rresp", {30'h0, r}, {30'h0, nfc_timer_pkg::RESP_SLVERR});
      h.wr(8'h20, 32'h0);
      chk("bresp", {30'h0, h.last_bresp}, {30'h0, nfc_timer_pkg::RESP_SLVERR});
      h.wr(nfc_timer_pkg::NRT_OFS, 32'h1);
      tx_end();
      cyc(30);
      chk("rx_on", {31'h0, rx_on}, 32'h1);
      cyc(60);
      chk("rx_on", {31'h0, rx_on}, 32'h0);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h1);
      h.wr(nfc_timer_pkg::IRQ_OFS, 32'h3F);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h1);
      tx_end();
      cyc(100);
      rdc(nfc_timer_pkg::STAT_OFS, 32'h11);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h2);
      cyc(3);
      rdc(nfc_timer_pkg::STAT_OFS, 32'h10);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h0);
      tx_end();
      cyc(10);
      @(posedge clk_i) rx_st <= 1'h1;
      @(posedge clk_i) rx_st <= 1'h0;
      cyc(100);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h0);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h2);
      busy <= 1'h1;
      tx_end();
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h10);
      cyc(100);
      chk("rx_on", {31'h0, rx_on}, 32'h1);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h1);
      busy <= 1'h0;
      h.wr(nfc_timer_pkg::IRQ_OFS, 32'h3F);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h1);
      cyc(40);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h1);
      cyc(40);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h0);
      cyc(30);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h1);
      h.wr(nfc_timer_pkg::IRQ_OFS, 32'h3F);
      h.wr(nfc_timer_pkg::GPT_OFS, 32'h1);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h4);
      cyc(100);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h2);
      h.wr(nfc_timer_pkg::IRQ_OFS, 32'h3F);
      h.wr(nfc_timer_pkg::WUT_OFS, 32'h2);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h8);
      cyc(3);
      chk("rc_osc_en", {31'h0, osc}, 32'h1);
      repeat (2) begin
         @(posedge clk_i) rc <= 1'h1;
         @(posedge clk_i) rc <= 1'h0;
      end
      cyc(3);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h20);
      chk("rc_osc_en", {31'h0, osc}, 32'h0);
      h.wr(nfc_timer_pkg::IRQ_OFS, 32'h3F);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h300);
      cyc(3);
      chk("fd_enable", {30'h0, fd}, 32'h3);
      ext <= 1'h1;
      cyc(5);
      ext <= 1'h0;
      cyc(5);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h18);
      h.wr(nfc_timer_pkg::PFW_OFS, 32'h1);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h30);
      @(posedge clk_i) {fo, eor} <= 2'h3;
      @(posedge clk_i) {fo, eor} <= 2'h0;
      cyc(3);
      rdc(nfc_timer_pkg::STAT_OFS, 32'h07);
      ext <= 1'h1;
      cyc(100);
      rdc(nfc_timer_pkg::IRQ_OFS, 32'h1B);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h24);
      ext <= 1'h0;
      cyc(2);
      ext <= 1'h1;
      cyc(3);
      rdc(nfc_timer_pkg::STAT_OFS, 32'h21);
      h.wr(nfc_timer_pkg::CMD_OFS, 32'h2);
      h.wr(nfc_timer_pkg::CTRL_OFS, 32'h80);
      ext <= 1'h0;
      tx_end();
      ext <= 1'h1;
      cyc(3);
      rdc(nfc_timer_pkg::STAT_OFS, 32'h38);
      results();
   end
endmodule : tb
